// file: core/afe_ctl_regs.vh
// register offsets, field positions and reset values for the front-end control bank
// Summary of operation
// - buffer control at 0x16, resets to zero
// - bits 7:6 select positive reference buffering
// - bits 5:4 select negative reference buffering
// - bit 1 disables positive input precharge
// - bit 0 disables negative input precharge
// - chop/common-mode register at 0x17, resets zero
// - bit 7 picks chop divide 32 or 8
// - bits 2:0 select common-mode output level
`ifndef AFE_CTL_REGS_VH
`define AFE_CTL_REGS_VH
`define AFE_ADDR_BUF 8'h16
`define AFE_ADDR_CM 8'h17
`define AFE_BUF_RST 8'h00
`define AFE_CM_RST 8'h00
`define AFE_BUF_WMASK 8'hf3
`define AFE_CM_WMASK 8'h87
`define AFE_REFP_HI 7
`define AFE_REFP_LO 6
`define AFE_REFN_HI 5
`define AFE_REFN_LO 4
`define AFE_AINP_OFF 1
`define AFE_AINN_OFF 0
`define AFE_CHOP_BIT 7
`define AFE_CMSEL_HI 2
`define AFE_CMSEL_LO 0
`define AFE_REF_PRECHG 2'h0
`define AFE_REF_UNBUF 2'h1
`define AFE_REF_FULL 2'h2
`define AFE_REF_UNDEF 2'h3
`define AFE_CMSEL_HALF 3'h0
`define AFE_CMSEL_OFF 3'h7
`define AFE_CHOP_DIV32 8'h20
`define AFE_CHOP_DIV8 8'h08
`endif

// file: core/afe_ref_dec.v
// decoder of one two-bit reference buffering select
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctl_regs.vh"
module afe_ref_dec (
   input wire [1:0] sel,
   output wire precharge_on,
   output wire unbuffered,
   output wire full_on,
   output wire undefined_code
);
   // one-hot decode; code 11 sets none of the three buffer modes
   assign precharge_on = (sel == `AFE_REF_PRECHG);
   assign unbuffered = (sel == `AFE_REF_UNBUF);
   assign full_on = (sel == `AFE_REF_FULL);
   assign undefined_code = (sel == `AFE_REF_UNDEF);
endmodule
`default_nettype wire

// file: core/afe_ctl.v
// front-end buffer and common-mode/chop control register bank
`timescale 1ns/1ps
`default_nettype none
`include "afe_ctl_regs.vh"
module afe_ctl (
   // clock, reset and freeze control
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   // register access from the serial interface
   input wire [7:0] reg_addr, // register address from the serial interface
   input wire reg_wr, // one-cycle write strobe
   input wire reg_rd, // one-cycle read strobe
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata, // registered read data
   output reg reg_rvalid, // read answer pulse
   // reference buffering selects and their decodes
   output reg [1:0] pos_reference_buffering,
   output reg [1:0] neg_reference_buffering,
   output reg ref_pos_precharge_on,
   output reg ref_pos_unbuffered,
   output reg ref_pos_full_on,
   output reg ref_neg_precharge_on,
   output reg ref_neg_unbuffered,
   output reg ref_neg_full_on,
   output reg ref_code_undefined, // either select holds code 11
   // analog input precharge buffer disables
   output reg pos_input_precharge_disable,
   output reg neg_input_precharge_disable,
   // modulator chop rate
   output reg chop_fast, // high: chop at modulator clock / 8
   output reg [7:0] chop_divider, // modulator clock divide for chopping
   // common-mode output level
   output reg [2:0] common_mode_output_select,
   output reg common_mode_half_supply,
   output reg common_mode_output_off
);

   // a write lands in the stored word at the edge that takes it;
   // the outputs follow one edge later, a read answers at the edge that takes it
   // stored register words
   reg [7:0] buf_reg; // front_end_buffer_control
   reg [7:0] cm_reg; // common_mode_chop_control
   // write values with reserved positions forced low
   wire [7:0] buf_next; // next value of buf_reg on a write
   wire [7:0] cm_next; // next value of cm_reg on a write
   // address matches for the two mapped offsets
   wire hit_buf; // strobe targets the buffer control word
   wire hit_cm; // strobe targets the chop and common-mode word
   // strobes qualified by the clock enable
   wire wr_take; // write accepted at this edge
   wire rd_take; // read accepted at this edge
   // read data picked for the answer register
   reg [7:0] rdata_next;
   // both reference selects packed, positive in the upper pair
   wire [3:0] ref_sel;
   // per-reference decodes, index 1 positive, index 0 negative
   wire [1:0] dec_pre; // precharge buffer on
   wire [1:0] dec_unb; // reference unbuffered
   wire [1:0] dec_full; // full buffer on
   wire [1:0] dec_und; // undocumented code 11
   // common-mode field and its decodes
   wire [2:0] cm_sel; // stored level select
   wire cm_half; // half analog supply
   wire cm_off; // output switched off
   // chop rate field and the divider it implies
   wire chop_sel; // high picks the faster chop
   wire [7:0] chop_div_next; // divide value for the chop counter
   // index of the decoder generate loop
   genvar g;

   // address decode; any other offset is unmapped
   assign hit_buf = (reg_addr == `AFE_ADDR_BUF);
   assign hit_cm = (reg_addr == `AFE_ADDR_CM);
   // a frozen bank takes no strobe at all
   assign wr_take = clk_en & reg_wr;
   assign rd_take = clk_en & reg_rd;
   // reserved positions masked so they stay zero; code 11 kept as written
   assign buf_next = reg_wdata & `AFE_BUF_WMASK;
   assign cm_next = reg_wdata & `AFE_CM_WMASK;

   // register storage, cleared by reset
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // both words come up cleared
         buf_reg <= `AFE_BUF_RST;
         cm_reg <= `AFE_CM_RST;
      end else if (wr_take) begin
         // only the addressed word moves
         if (hit_buf) begin
            buf_reg <= buf_next;
         end
         if (hit_cm) begin
            cm_reg <= cm_next;
         end
      end
   end

   // read multiplexer; unmapped addresses read zero
   // a pure decode of the stored words, so a read taken with a write
   // at the same edge still returns the old value
   always @* begin
      rdata_next = 8'h00;
      case (reg_addr)
         `AFE_ADDR_BUF: begin
            rdata_next = buf_reg;
         end
         `AFE_ADDR_CM: begin
            rdata_next = cm_reg;
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   // one decoder per reference; both selects share the same code meanings
   assign ref_sel = {buf_reg[`AFE_REFP_HI:`AFE_REFP_LO],
      buf_reg[`AFE_REFN_HI:`AFE_REFN_LO]};
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_ref
         // g = 1 decodes the positive select, g = 0 the negative one
         afe_ref_dec u_dec (
            .sel(ref_sel[2 * g + 1:2 * g]),
            .precharge_on(dec_pre[g]),
            .unbuffered(dec_unb[g]),
            .full_on(dec_full[g]),
            .undefined_code(dec_und[g])
         );
      end
   endgenerate

   // common-mode decode; codes 1 to 6 are fixed levels with no flag
   assign cm_sel = cm_reg[`AFE_CMSEL_HI:`AFE_CMSEL_LO];
   assign cm_half = (cm_sel == `AFE_CMSEL_HALF);
   assign cm_off = (cm_sel == `AFE_CMSEL_OFF);
   // chop rate; the slow rate is the reset default
   assign chop_sel = cm_reg[`AFE_CHOP_BIT];
   assign chop_div_next = chop_sel ? `AFE_CHOP_DIV8 : `AFE_CHOP_DIV32;

   // read answer: data and a one-cycle valid pulse
   // rdata holds between reads so a slow host may fetch it late
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // no answer pending after reset
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else if (clk_en) begin
         // valid pulses once per accepted read
         reg_rvalid <= reg_rd;
         if (rd_take) begin
            reg_rdata <= rdata_next;
         end
      end
   end

   // reference buffering outputs, one edge behind the stored word
   // the extra stage keeps every top-level output on a flip-flop
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // cleared selects decode as precharge on
         pos_reference_buffering <= 2'h0;
         neg_reference_buffering <= 2'h0;
         ref_pos_precharge_on <= 1'b1;
         ref_pos_unbuffered <= 1'b0;
         ref_pos_full_on <= 1'b0;
         ref_neg_precharge_on <= 1'b1;
         ref_neg_unbuffered <= 1'b0;
         ref_neg_full_on <= 1'b0;
         ref_code_undefined <= 1'b0;
      end else if (clk_en) begin
         pos_reference_buffering <= ref_sel[3:2];
         neg_reference_buffering <= ref_sel[1:0];
         ref_pos_precharge_on <= dec_pre[1];
         ref_pos_unbuffered <= dec_unb[1];
         ref_pos_full_on <= dec_full[1];
         ref_neg_precharge_on <= dec_pre[0];
         ref_neg_unbuffered <= dec_unb[0];
         ref_neg_full_on <= dec_full[0];
         // code 11 leaves all three modes low and raises this flag
         ref_code_undefined <= |dec_und;
      end
   end

   // analog input precharge buffer disables, high turns a buffer off
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // both buffers enabled after reset
         pos_input_precharge_disable <= 1'b0;
         neg_input_precharge_disable <= 1'b0;
      end else if (clk_en) begin
         // each follows its stored bit
         pos_input_precharge_disable <= buf_reg[`AFE_AINP_OFF];
         neg_input_precharge_disable <= buf_reg[`AFE_AINN_OFF];
      end
   end

   // chop rate outputs; the divider saves the modulator a decode
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // slow chop after reset
         chop_fast <= 1'b0;
         chop_divider <= `AFE_CHOP_DIV32;
      end else if (clk_en) begin
         // flag and divider always move together
         chop_fast <= chop_sel;
         chop_divider <= chop_div_next;
      end
   end

   // common-mode outputs
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // code 0, half supply, after reset
         common_mode_output_select <= 3'h0;
         common_mode_half_supply <= 1'b1;
         common_mode_output_off <= 1'b0;
      end else if (clk_en) begin
         // raw select plus the two levels worth a flag
         common_mode_output_select <= cm_sel;
         common_mode_half_supply <= cm_half;
         common_mode_output_off <= cm_off;
      end
   end
endmodule
`default_nettype wire

// file: verif/afe_ctl_properties.sv
// port checker for the front-end control bank
`timescale 1ns/1ps
`default_nettype none
module afe_ctl_properties (
   input wire logic clk, rst_n, clk_en, reg_wr, reg_rd, reg_rvalid,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, chop_divider,
   input wire logic [1:0] pos_reference_buffering, neg_reference_buffering,
   input wire logic ref_pos_precharge_on, ref_pos_unbuffered, ref_pos_full_on,
   input wire logic ref_neg_precharge_on, ref_neg_unbuffered, ref_neg_full_on,
   input wire logic ref_code_undefined, pos_input_precharge_disable, chop_fast,
   input wire logic neg_input_precharge_disable, common_mode_half_supply,
   input wire logic common_mode_output_off,
   input wire logic [2:0] common_mode_output_select
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // short aliases keep the properties readable
   wire logic [1:0] p = pos_reference_buffering;
   wire logic [1:0] n = neg_reference_buffering;
   wire logic [2:0] s = common_mode_output_select;
   wire logic w16 = clk_en && reg_wr && reg_addr == 8'h16;
   wire logic w17 = clk_en && reg_wr && reg_addr == 8'h17;
   // bits a read may show; unmapped places show none
   wire logic [7:0] keep = reg_addr == 8'h16 ? 8'hf3 : reg_addr == 8'h17 ? 8'h87 : 8'h00;
   AST_WR_BUF: assert property (w16 ##1 clk_en |-> ##1
      {p, n, pos_input_precharge_disable, neg_input_precharge_disable}
      == {$past(reg_wdata[7:4], 2), $past(reg_wdata[1:0], 2)}) else $error("buffer write lost");
   AST_POS_DEC: assert property ({ref_pos_precharge_on, ref_pos_unbuffered, ref_pos_full_on}
      == {p == 2'h0, p == 2'h1, p == 2'h2}) else $error("positive decode wrong");
   AST_NEG_DEC: assert property ({ref_neg_precharge_on, ref_neg_unbuffered, ref_neg_full_on}
      == {n == 2'h0, n == 2'h1, n == 2'h2}) else $error("negative decode wrong");
   AST_UNDEF: assert property (ref_code_undefined == (p == 2'h3 || n == 2'h3))
      else $error("undefined code flag wrong");
   AST_WR_CM: assert property (w17 ##1 clk_en |-> ##1 {chop_fast, s}
      == {$past(reg_wdata[7], 2), $past(reg_wdata[2:0], 2)}) else $error("chop write lost");
   AST_CHOP: assert property (chop_divider == (chop_fast ? 8'h08 : 8'h20))
      else $error("chop divider wrong");
   AST_CM_DEC: assert property ({common_mode_half_supply, common_mode_output_off}
      == {s == 3'h0, s == 3'h7}) else $error("common mode decode wrong");
   AST_RD: assert property (clk_en && reg_rd |=> reg_rvalid &&
      (reg_rdata & ~$past(keep)) == 8'h00) else $error("read answer wrong");
   AST_RD_BUF: assert property (clk_en && reg_rd && reg_addr == 8'h16 |=> reg_rdata ==
      {p, n, 2'h0, pos_input_precharge_disable, neg_input_precharge_disable})
      else $error("buffer read wrong");
   AST_RD_CM: assert property (clk_en && reg_rd && reg_addr == 8'h17 |=> reg_rdata ==
      {chop_fast, 4'h0, s}) else $error("chop read wrong");
   AST_RVALID: assert property (clk_en && !reg_rd |=> !reg_rvalid)
      else $error("read answer without a read");
endmodule
bind afe_ctl afe_ctl_properties u_prop (.*);
`default_nettype wire

// file: verif/tb_afe_ctl.sv
// self-checking bench for the front-end control bank
`timescale 1ns/1ps
`default_nettype none
module tb_afe_ctl;
   logic clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, m16, m17, d; // bank model
   wire [7:0] reg_rdata, chop_divider;
   wire [1:0] pos_reference_buffering, neg_reference_buffering;
   wire [2:0] common_mode_output_select;
   wire reg_rvalid, ref_pos_precharge_on, ref_pos_unbuffered, ref_pos_full_on;
   wire ref_neg_precharge_on, ref_neg_unbuffered, ref_neg_full_on, ref_code_undefined;
   wire pos_input_precharge_disable, neg_input_precharge_disable, chop_fast;
   wire common_mode_half_supply, common_mode_output_off;
   int n_mismatch = 0, check_count = 0;
   afe_ctl DUT (.*);
   always #2.5 clk = ~clk;
   // expected read data; unmapped places read zero
   function automatic logic [7:0] expect_rd(input logic [7:0] a);
      return a == 8'h16 ? m16 : a == 8'h17 ? m17 : 8'h00;
   endfunction
   // reference decodes from the code meanings
   function automatic logic [7:0] exp_ref(input logic [7:0] b);
      return {2'h0, b[7:6] == 2'h0, b[7:6] == 2'h1, b[7:6] == 2'h2,
         b[5:4] == 2'h0, b[5:4] == 2'h1, b[5:4] == 2'h2};
   endfunction
   // code 11 flag, chop rate and common-mode flags
   function automatic logic [7:0] exp_cm(input logic [7:0] b, c);
      return {b[7:6] == 2'h3 || b[5:4] == 2'h3, c[7], c[2:0] == 3'h0, c[2:0] == 3'h7,
         1'b0, c[2:0]};
   endfunction
   task automatic chk(input logic [7:0] got, exp);
      check_count++;
      if (got !== exp) begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask
   // one-cycle write strobe; model drops reserved bits
   task automatic wr(input logic [7:0] a, v);
      @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
      if (clk_en && a == 8'h16) m16 = v & 8'hf3;
      if (clk_en && a == 8'h17) m17 = v & 8'h87;
   endtask
   // answer lands at the same edge that takes the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk({7'h00, reg_rvalid}, {7'h00, clk_en});
      if (clk_en) chk(reg_rdata, expect_rd(a));
   endtask
   // every decoded output against the bank model
   task automatic chk_outs;
      chk(chop_divider, m17[7] ? 8'h08 : 8'h20);
      chk({pos_reference_buffering, neg_reference_buffering, 2'h0,
         pos_input_precharge_disable, neg_input_precharge_disable}, m16);
      chk({2'h0, ref_pos_precharge_on, ref_pos_unbuffered, ref_pos_full_on,
         ref_neg_precharge_on, ref_neg_unbuffered, ref_neg_full_on}, exp_ref(m16));
      chk({ref_code_undefined, chop_fast, common_mode_half_supply,
         common_mode_output_off, 1'b0, common_mode_output_select}, exp_cm(m16, m17));
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // hang guard
   initial begin
      #200000;
      n_mismatch++;
      close_out;
   end
   initial begin
      void'($urandom(32'hdb4f));
      m16 = 8'h00;
      m17 = 8'h00;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk(chop_divider, 8'h20);
      chk({7'h00, ref_pos_precharge_on}, 8'h01);
      chk_outs;
      rd(8'h16);
      rd(8'h17);
      // first passes walk every code, then random data
      for (int i = 0; i < 48; i++) begin
         d = 8'($urandom);
         if (i < 8) d = {i[1:0], i[1:0], 1'b1, i[2:0]};
         wr(8'h16, d);
         wr(8'h17, d);
         wr({1'b1, d[6:0]}, ~d);
         rd(8'h16);
         rd(8'h17);
         rd({1'b1, d[6:0]});
         chk_outs;
      end
      // frozen bank ignores both strobes
      @(posedge clk) clk_en <= 1'b0;
      wr(8'h16, 8'h55);
      rd(8'h16);
      @(posedge clk) clk_en <= 1'b1;
      rd(8'h16);
      // reset in mid-run clears both registers
      @(posedge clk) rst_n <= 1'b0;
      @(posedge clk) rst_n <= 1'b1;
      m16 = 8'h00;
      m17 = 8'h00;
      rd(8'h16);
      rd(8'h17);
      chk_outs;
      close_out;
   end
endmodule
`default_nettype wire
